// ===== rtl/serial_port_pkg.sv
// Constants, types and register map of the serial I/O port.
// Assumes a single peripheral clock and an AHB-Lite register bus.
package serial_port_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BUF = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_RELOAD = 8'h0C;
  localparam logic [7:0] ADDR_PWR = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [7:0] ADDR_MASK = 8'h18;
  localparam logic [7:0] ADDR_SADDR = 8'h1C;
  localparam int ADDR_LSB = 0;
  localparam int ADDR_MSB = 7;

  // serial_control_reg fields
  localparam int CTL_MODE_HI = 7;
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_MP_EN = 5;
  localparam int CTL_RX_EN = 4;
  localparam int CTL_TX_NINTH = 3;
  localparam int CTL_RX_NINTH = 2;
  localparam int CTL_TX_DONE = 1;
  localparam int CTL_RX_DONE = 0;

  // baud_gen_control_reg fields
  localparam int BC_RUN = 4;
  localparam int BC_T1_SEL = 2;
  localparam int BC_SPD = 1;
  localparam int BC_M0_VAR = 0;

  // power_control_reg field
  localparam int PWR_DOUBLE = 7;

  // Event bits of status and mask registers
  localparam int EV_RX_DONE = 0;
  localparam int EV_TX_DONE = 1;
  localparam int EV_FRAME_ERR = 2;
  localparam int EV_W = 3;

  // Timing
  localparam int CORE_CLK_HZ = 20_000_000;
  localparam logic [2:0] PRESCALE_LAST = 3'h5;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TICK_SAMPLE = 4'h8;
  localparam logic [3:0] TICK_HALF_END = 4'h7;
  localparam logic [2:0] BITS_LAST = 3'h7;
  localparam logic [7:0] CNT_TOP = 8'hFF;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {MODE_SHIFT, MODE_UART8, MODE_UART9_FIX,
    MODE_UART9_VAR} mode_t;

  typedef struct packed {
    logic run;
    logic baud_speed_select;
    logic t1_sel;
    logic m0_var;
    logic dbl;
    logic [7:0] reload;
  } baud_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic ninth;
    logic stop_ok;
  } rx_frame_t;

endpackage : serial_port_pkg

// ===== rtl/serial_baud_gen.sv
// Baud tick source: core clock, internal 8-bit auto-reload generator or timer 1.
// Assumes t1_ovf is a one-cycle pulse synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module serial_baud_gen (
  input wire logic clk,
  input wire logic rst,
  input wire serial_port_pkg::baud_cfg_t cfg,
  input wire serial_port_pkg::mode_t mode,
  input wire logic t1_ovf,
  output logic tick
);
  import serial_port_pkg::*;

  logic [2:0] pre_r;
  logic [7:0] cnt_r;
  logic half_r;
  logic step;
  logic gen_ovf;
  logic src;

  assign step = cfg.baud_speed_select | (pre_r == PRESCALE_LAST);
  assign gen_ovf = cfg.run & step & (cnt_r == CNT_TOP);

  always_ff @(posedge clk) begin
    if (rst || !cfg.run || cfg.baud_speed_select) begin
      pre_r <= '0;
    end else begin
      pre_r <= (pre_r == PRESCALE_LAST) ? '0 : pre_r + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (cfg.run && step) begin
      cnt_r <= (cnt_r == CNT_TOP) ? cfg.reload : cnt_r + 8'h01;
    end
  end

  always_comb begin
    case (mode)
      MODE_SHIFT: src = cfg.m0_var ? gen_ovf : 1'b1;
      MODE_UART8, MODE_UART9_VAR: src = cfg.t1_sel ? t1_ovf : gen_ovf;
      MODE_UART9_FIX: src = 1'b1;
      default: src = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      half_r <= 1'b0;
    end else if (src) begin
      half_r <= ~half_r;
    end
  end

  assign tick = src & (cfg.dbl | half_r);

endmodule : serial_baud_gen
`default_nettype wire

// ===== rtl/serial_async_rx.sv
// Asynchronous receiver with 16 ticks per bit, mid-bit sampling.
// Assumes rxd is synchronous to clk and tick is a one-cycle pulse.
`timescale 1ns/100ps
`default_nettype none
module serial_async_rx (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic nine,
  input wire logic tick,
  input wire logic rxd,
  output logic done,
  output serial_port_pkg::rx_frame_t frame
);
  import serial_port_pkg::*;

  typedef enum {RX_IDLE, RX_START, RX_BITS, RX_STOP} rx_state_t;
  rx_state_t st_r;
  logic [3:0] tk_r;
  logic [3:0] bit_r;
  logic [8:0] sh_r;
  logic [3:0] nbits;

  assign nbits = nine ? 4'h8 : 4'h7;

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= RX_IDLE;
      tk_r <= '0;
      bit_r <= '0;
      sh_r <= '0;
      done <= 1'b0;
      frame <= '0;
    end else begin
      done <= 1'b0;
      case (st_r)
        RX_IDLE: begin
          tk_r <= '0;
          if (enable && !rxd) begin
            st_r <= RX_START;
          end
        end
        RX_START: begin
          if (tick) begin
            tk_r <= tk_r + 4'h1;
            if (tk_r == TICK_SAMPLE && rxd) begin
              st_r <= RX_IDLE;
            end else if (tk_r == TICK_LAST) begin
              st_r <= RX_BITS;
              bit_r <= '0;
            end
          end
        end
        RX_BITS: begin
          if (tick) begin
            tk_r <= tk_r + 4'h1;
            if (tk_r == TICK_SAMPLE) begin
              sh_r <= {rxd, sh_r[8:1]};
            end
            if (tk_r == TICK_LAST) begin
              bit_r <= bit_r + 4'h1;
              if (bit_r == nbits) begin
                st_r <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (tick) begin
            tk_r <= tk_r + 4'h1;
            if (tk_r == TICK_SAMPLE) begin
              frame.data <= nine ? sh_r[7:0] : sh_r[8:1];
              frame.ninth <= nine ? sh_r[8] : rxd;
              frame.stop_ok <= rxd;
              done <= 1'b1;
              st_r <= RX_IDLE;
            end
          end
        end
        default: st_r <= RX_IDLE;
      endcase
    end
  end

endmodule : serial_async_rx
`default_nettype wire

// ===== rtl/serial_port.sv
// Serial I/O port: shift-register mode and three UART modes, AHB-Lite.
// Assumes one peripheral clock; timer 1 overflow arrives as a pulse.
// Notes on behaviour
// - Mode field 00 shift register, 01 8-bit UART, 10/11 9-bit UART.
// - Mode 0 is the only synchronous mode, receive and transmit.
// - Modes 1 to 3 are asynchronous and full duplex.
// - Asynchronous modes flag framing errors; modes 2 and 3 filter by own address.
// - Timer 1 overflow may drive the baud clock in modes 1 and 3 only.
// - Internal generator serves modes 0, 1 and 3; mode 2 is fixed.
// - Timer 1 baud clock comes from its 8-bit auto-reload overflows.
// - The doubling bit doubles the rate from either source.
// - Internal generator is 8-bit auto-reload, clock or clock/6.
// - Internal generator counts only while its run bit is set.
// - Mode 0 gives eight clocks on TXD, one byte on RXD, LSB first.
// - Buffer write starts mode 0 send; then RXD high, done flag set.
// - Mode 1 frame: start, eight data, stop; stop kept as ninth bit.
// - Modes 2, 3 add a programmable ninth bit sent and stored.
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module serial_port (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic T1_OVF,
  output logic TXD,
  input wire logic RXD_I,
  output logic RXD_O,
  output logic RXD_OE,
  output logic IRQ
);
  import serial_port_pkg::*;

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP} tx_state_t;

  function automatic mode_t decode_mode(input logic hi, input logic lo);
    case ({hi, lo})
      2'b00: decode_mode = MODE_SHIFT;
      2'b01: decode_mode = MODE_UART8;
      2'b10: decode_mode = MODE_UART9_FIX;
      default: decode_mode = MODE_UART9_VAR;
    endcase
  endfunction : decode_mode

  function automatic logic has_ninth(input mode_t m);
    has_ninth = (m == MODE_UART9_FIX) || (m == MODE_UART9_VAR);
  endfunction : has_ninth

  // Registers
  logic [7:0] ctrl_r;
  logic [7:0] baud_ctl_r;
  logic [7:0] reload_r;
  logic [7:0] pwr_r;
  logic [7:0] rx_buf_r;
  logic [EV_W-1:0] stat_r;
  logic [EV_W-1:0] mask_r;
  logic [15:0] saddr_r;
  logic rx_ninth_r;

  // Bus
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rdata_r;
  logic addr_ok;
  logic wr_ctrl;
  logic wr_buf;

  // Shift engine
  tx_state_t st_r;
  logic [3:0] tk_r;
  logic [2:0] bit_r;
  logic [7:0] sh_r;
  logic ninth_r;
  logic m0_rx_r;
  logic txd_r;
  logic rxd_o_r;
  logic tx_done_ev;
  logic m0_rx_ev;

  // Async receive
  logic tick;
  logic arx_done;
  rx_frame_t arx_frame;
  logic accept;
  logic addr_hit;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;

  mode_t mode;
  baud_cfg_t cfg;

  assign mode = decode_mode(ctrl_r[CTL_MODE_HI], ctrl_r[CTL_MODE_LO]);

  assign cfg.run = baud_ctl_r[BC_RUN];
  assign cfg.baud_speed_select = baud_ctl_r[BC_SPD];
  assign cfg.t1_sel = baud_ctl_r[BC_T1_SEL];
  assign cfg.m0_var = baud_ctl_r[BC_M0_VAR];
  assign cfg.dbl = pwr_r[PWR_DOUBLE];
  assign cfg.reload = reload_r;

  serial_baud_gen u_baud (
    .clk(CORE_CLK),
    .rst(RST),
    .cfg(cfg),
    .mode(mode),
    .t1_ovf(T1_OVF),
    .tick(tick)
  );

  serial_async_rx u_rx (
    .clk(CORE_CLK),
    .rst(RST),
    .enable(ctrl_r[CTL_RX_EN] && mode != MODE_SHIFT),
    .nine(has_ninth(mode)),
    .tick(tick),
    .rxd(RXD_I),
    .done(arx_done),
    .frame(arx_frame)
  );

  // AHB-Lite slave: zero wait states, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_r;

  assign addr_ok = HSEL && HTRANS[1] && HREADY;
  assign wr_ctrl = wr_pend_r && (wr_addr_r == ADDR_CTRL);
  assign wr_buf = wr_pend_r && (wr_addr_r == ADDR_BUF);

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else begin
      wr_pend_r <= addr_ok && HWRITE;
      wr_addr_r <= HADDR[ADDR_MSB:ADDR_LSB];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rdata_r <= ZERO_WORD;
    end else if (addr_ok && !HWRITE) begin
      rdata_r <= ZERO_WORD;
      case (HADDR[ADDR_MSB:ADDR_LSB])
        ADDR_CTRL: begin
          rdata_r[7:0] <= {ctrl_r[7:3], rx_ninth_r,
            stat_r[EV_TX_DONE], stat_r[EV_RX_DONE]};
        end
        ADDR_BUF: rdata_r[7:0] <= rx_buf_r;
        ADDR_BAUD: rdata_r[7:0] <= baud_ctl_r;
        ADDR_RELOAD: rdata_r[7:0] <= reload_r;
        ADDR_PWR: rdata_r[7:0] <= pwr_r;
        ADDR_STAT: rdata_r[EV_W-1:0] <= stat_r;
        ADDR_MASK: rdata_r[EV_W-1:0] <= mask_r;
        ADDR_SADDR: rdata_r[15:0] <= saddr_r;
        default: rdata_r <= ZERO_WORD;
      endcase
    end
  end

  // Writable configuration
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ctrl_r <= '0;
      baud_ctl_r <= '0;
      reload_r <= '0;
      pwr_r <= '0;
      mask_r <= '0;
      saddr_r <= '0;
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        ADDR_CTRL: ctrl_r <= {HWDATA[7:3], 3'b000};
        ADDR_BAUD: baud_ctl_r <= HWDATA[7:0];
        ADDR_RELOAD: reload_r <= HWDATA[7:0];
        ADDR_PWR: pwr_r <= HWDATA[7:0];
        ADDR_MASK: mask_r <= HWDATA[EV_W-1:0];
        ADDR_SADDR: saddr_r <= HWDATA[15:0];
        default: ;
      endcase
    end
  end

  // Address filter for multiprocessor reception
  assign addr_hit = ((arx_frame.data ^ saddr_r[7:0]) & saddr_r[15:8]) ==
    8'h00;

  always_comb begin
    accept = arx_done && arx_frame.stop_ok && !stat_r[EV_RX_DONE];
    if (ctrl_r[CTL_MP_EN] && has_ninth(mode)) begin
      accept = accept && arx_frame.ninth && addr_hit;
    end
  end

  // Received data and ninth bit
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rx_buf_r <= '0;
      rx_ninth_r <= 1'b0;
    end else if (accept) begin
      rx_buf_r <= arx_frame.data;
      rx_ninth_r <= arx_frame.ninth;
    end else if (m0_rx_ev) begin
      rx_buf_r <= {RXD_I, sh_r[7:1]};
    end
  end

  // Shift engine: mode 0 both directions, async transmit
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st_r <= TX_IDLE;
      tk_r <= '0;
      bit_r <= '0;
      sh_r <= '0;
      ninth_r <= 1'b0;
      m0_rx_r <= 1'b0;
      txd_r <= 1'b1;
      rxd_o_r <= 1'b1;
    end else begin
      case (st_r)
        TX_IDLE: begin
          tk_r <= '0;
          bit_r <= '0;
          txd_r <= 1'b1;
          rxd_o_r <= 1'b1;
          if (wr_buf) begin
            sh_r <= HWDATA[7:0];
            ninth_r <= ctrl_r[CTL_TX_NINTH];
            m0_rx_r <= 1'b0;
            st_r <= (mode == MODE_SHIFT) ? TX_DATA : TX_START;
            if (mode == MODE_SHIFT) begin
              rxd_o_r <= HWDATA[0];
            end else begin
              tk_r <= TICK_LAST;
            end
          end else if (wr_ctrl && !HWDATA[CTL_MODE_HI] &&
            !HWDATA[CTL_MODE_LO] && HWDATA[CTL_RX_EN]) begin
            m0_rx_r <= 1'b1;
            st_r <= TX_DATA;
          end
        end
        TX_START: begin
          if (tick) begin
            tk_r <= tk_r + 4'h1;
            if (tk_r == TICK_LAST && txd_r) begin
              txd_r <= 1'b0;
            end else if (tk_r == TICK_LAST) begin
              st_r <= TX_DATA;
              txd_r <= sh_r[0];
            end
          end
        end
        TX_DATA: begin
          if (tick) begin
            tk_r <= tk_r + 4'h1;
            if (mode == MODE_SHIFT && tk_r == TICK_HALF_END) begin
              txd_r <= 1'b0;
            end
            if (tk_r == TICK_LAST) begin
              bit_r <= bit_r + 3'h1;
              if (m0_rx_r) begin
                sh_r <= {RXD_I, sh_r[7:1]};
              end else begin
                sh_r <= {1'b0, sh_r[7:1]};
              end
              if (mode == MODE_SHIFT) begin
                txd_r <= 1'b1;
                rxd_o_r <= (bit_r == BITS_LAST) ? 1'b1 : sh_r[1];
              end else begin
                txd_r <= sh_r[1];
              end
              if (bit_r == BITS_LAST) begin
                if (mode == MODE_SHIFT) begin
                  st_r <= TX_IDLE;
                end else if (has_ninth(mode)) begin
                  st_r <= TX_NINTH;
                  txd_r <= ninth_r;
                end else begin
                  st_r <= TX_STOP;
                  txd_r <= 1'b1;
                end
              end
            end
          end
        end
        TX_NINTH: begin
          if (tick) begin
            tk_r <= tk_r + 4'h1;
            if (tk_r == TICK_LAST) begin
              st_r <= TX_STOP;
              txd_r <= 1'b1;
            end
          end
        end
        TX_STOP: begin
          if (tick) begin
            tk_r <= tk_r + 4'h1;
            if (tk_r == TICK_LAST) begin
              st_r <= TX_IDLE;
            end
          end
        end
        default: st_r <= TX_IDLE;
      endcase
    end
  end

  assign tx_done_ev = tick && tk_r == TICK_LAST && !m0_rx_r &&
    ((st_r == TX_STOP) ||
     (st_r == TX_DATA && mode == MODE_SHIFT && bit_r == BITS_LAST));
  assign m0_rx_ev = tick && tk_r == TICK_LAST && m0_rx_r &&
    st_r == TX_DATA && bit_r == BITS_LAST;

  // Pins
  assign TXD = txd_r;
  assign RXD_O = rxd_o_r;
  assign RXD_OE = (mode == MODE_SHIFT) && !m0_rx_r;

  // Sticky events: a set in the same cycle as a clear wins
  assign ev_set[EV_RX_DONE] = accept || m0_rx_ev;
  assign ev_set[EV_TX_DONE] = tx_done_ev;
  assign ev_set[EV_FRAME_ERR] = arx_done && !arx_frame.stop_ok;

  always_comb begin
    ev_clr = '0;
    if (wr_pend_r && wr_addr_r == ADDR_STAT) begin
      ev_clr = HWDATA[EV_W-1:0];
    end
    if (wr_ctrl && HWDATA[CTL_RX_EN] && !HWDATA[CTL_MODE_HI] &&
      !HWDATA[CTL_MODE_LO]) begin
      ev_clr[EV_RX_DONE] = 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < EV_W; g++) begin : g_ev
      always_ff @(posedge CORE_CLK) begin
        if (RST) begin
          stat_r[g] <= 1'b0;
        end else if (ev_set[g]) begin
          stat_r[g] <= 1'b1;
        end else if (ev_clr[g]) begin
          stat_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign IRQ = |(stat_r & mask_r);

endmodule : serial_port
`default_nettype wire

// ===== testbench/serial_port_properties.sv
// Concurrent checks on the serial port's top-level pins.
// Assumes it is bound to serial_port; one clock, sync active-high reset.
`timescale 1ns/100ps
`default_nettype none
module serial_port_properties
  import serial_port_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic T1_OVF,
  input wire logic TXD,
  input wire logic RXD_I,
  input wire logic RXD_O,
  input wire logic RXD_OE,
  input wire logic IRQ
);
  logic req;
  logic wr_dp_r;
  assign req = HSEL && HTRANS[1] && HREADY;
  // Marks the data phase of a write, when register effects land
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      wr_dp_r <= 1'h0;
    end else begin
      wr_dp_r <= req && HWRITE;
    end
  end
  sequence low_phase_s;
    !TXD [*8];
  endsequence
  sequence high_phase_s;
    TXD [*8];
  endsequence
  ready_high_a: assert property (@(posedge CORE_CLK) HREADYOUT)
    else $error("Ready output dropped");
  okay_resp_a: assert property (@(posedge CORE_CLK) !HRESP)
    else $error("Response not OKAY");
  reset_idle_a: assert property (@(posedge CORE_CLK)
    RST |=> TXD && RXD_O && RXD_OE && !IRQ && HRDATA == 32'h0000_0000)
    else $error("Outputs not idle under reset");
  unmapped_zero_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    req && !HWRITE && HADDR[7:0] > ADDR_SADDR |=> HRDATA == 32'h0000_0000)
    else $error("Unmapped read not zero");
  upper_zero_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    req && !HWRITE && HADDR[7:0] != ADDR_SADDR |=> HRDATA[31:8] == 24'h00_0000)
    else $error("Upper read bits not zero");
  rdata_hold_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    !(req && !HWRITE) |=> $stable(HRDATA))
    else $error("Read data moved without a read");
  low_run_a: assert property (
    @(posedge CORE_CLK) disable iff (RST) $fell(TXD) |-> low_phase_s)
    else $error("Serial output low phase too short");
  high_run_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(TXD) |-> high_phase_s)
    else $error("Serial output high phase too short");
  data_edge_a: assert property (
    @(posedge CORE_CLK) disable iff (RST) $changed(RXD_O) |-> TXD)
    else $error("Shift data moved while clock low");
  irq_fall_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    $fell(IRQ) |-> $past(wr_dp_r))
    else $error("Interrupt dropped without a write");
endmodule : serial_port_properties
`default_nettype wire

// ===== testbench/serial_peer.sv
// Behavioural far side: serial line peer and mode 0 shift register.
// Assumes the bench resolves the data pin and gives mode and frame size.
`timescale 1ns/100ps
`default_nettype none
module serial_peer (
  input wire logic clk,
  input wire logic txd,
  input wire logic rxd_o,
  input wire logic sync_mode,
  input wire logic nine,
  output logic rxd_drv
);
  logic [9:0] got_q[$];
  int len_q[$];
  logic [9:0] w;
  int n;
  longint t0;
  initial rxd_drv = 1'h1;
  // Captures every frame; start bit length gives the bit time
  always begin
    @(negedge txd);
    w = 10'h000;
    n = 0;
    if (sync_mode) begin
      for (int i = 0; i < 8; i++) begin
        if (i > 0) @(negedge txd);
        w[i] = rxd_o;
      end
    end else begin
      t0 = $time;
      @(posedge txd);
      n = int'(($time - t0) / 50);
      w[0] = 1'h1;
      #(n * 75);
      for (int i = 1; i < (nine ? 10 : 9); i++) begin
        w[(nine || i < 8) ? i : 9] = txd;
        #(n * 50);
      end
    end
    got_q.push_back(w);
    len_q.push_back(n);
  end
  // Sends start, data and ninth bits, then f[9] as stop
  task automatic send(input logic [9:0] f, input int nb, input int len);
    rxd_drv <= 1'h0;
    repeat (len) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      rxd_drv <= f[i];
      repeat (len) @(posedge clk);
    end
    rxd_drv <= f[9];
    repeat (len) @(posedge clk);
    rxd_drv <= 1'h1;
  endtask : send
  // Shift register output: next bit after each rising shift clock
  task automatic feed(input logic [7:0] b);
    rxd_drv <= b[0];
    for (int i = 1; i < 8; i++) begin
      @(posedge txd);
      rxd_drv <= b[i];
    end
    @(posedge txd);
    rxd_drv <= ~b[7];
  endtask : feed
endmodule : serial_peer
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the serial port: bus, async and shift modes.
// Assumes serial_port, serial_peer and serial_port_properties are built.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import serial_port_pkg::*;
  logic CORE_CLK, RST, HSEL, HWRITE, T1_OVF, HREADYOUT, HRESP, TXD, IRQ;
  logic [31:0] HADDR, HWDATA, HRDATA, seed;
  logic [1:0] HTRANS, t1_cnt;
  logic [2:0] HSIZE;
  logic RXD_I, RXD_O, RXD_OE, peer_drv, sync_m, nine_m, rd_pend;
  logic [31:0] exp_q[$], msk_q[$];
  logic [7:0] d;
  int error_cnt, check_count, cyc;
  assign RXD_I = RXD_OE ? RXD_O : peer_drv;
  serial_port i_serial_port (.CORE_CLK(CORE_CLK), .RST(RST), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .T1_OVF(T1_OVF), .TXD(TXD),
    .RXD_I(RXD_I), .RXD_O(RXD_O), .RXD_OE(RXD_OE), .IRQ(IRQ));
  serial_peer i_serial_peer (.clk(CORE_CLK), .txd(TXD), .rxd_o(RXD_O),
    .sync_mode(sync_m), .nine(nine_m), .rxd_drv(peer_drv));
  initial begin
    CORE_CLK = 1'h0;
    forever #25 CORE_CLK = ~CORE_CLK;
  end
  // Timer 1 overflow pulse every third clock
  always @(posedge CORE_CLK) begin
    t1_cnt <= (t1_cnt == 2'h2) ? 2'h0 : t1_cnt + 2'h1;
    T1_OVF <= (t1_cnt == 2'h2);
  end
  // Result watcher: read data against the oldest note, plus timeout
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (rd_pend) check(HRDATA & msk_q.pop_front(), exp_q.pop_front());
    if (cyc == 40000) begin
      error_cnt++;
      results();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] dt, input logic [31:0] m);
    HSEL <= 1'h1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h00_0000, a};
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'h1);
    HSEL <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= w ? dt : 32'h0000_0000;
    if (!w) begin
      exp_q.push_back(dt & m);
      msk_q.push_back(m);
    end
    rd_pend <= !w;
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'h1);
    rd_pend <= 1'h0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    bus(1'h1, a, {16'h0000, v}, 32'h0000_0000);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    bus(1'h0, a, e, m);
  endtask : rd
  task automatic take(input logic [9:0] e, input int ln);
    int k;
    k = 0;
    while (i_serial_peer.got_q.size() == 0 && k < 20000) begin
      @(posedge CORE_CLK);
      k++;
    end
    check({22'h00_0000, i_serial_peer.got_q.pop_front()}, {22'h00_0000, e});
    k = i_serial_peer.len_q.pop_front();
    if (ln > 0) check(k, ln);
  endtask : take
  task automatic tx_one(input logic [7:0] ctl, input logic [7:0] bd,
                        input logic [7:0] pw, input logic [7:0] rl, input int ln);
    d = 8'(rnd()) | 8'h01;
    nine_m <= ctl[7];
    wr(ADDR_RELOAD, {8'h00, rl});
    wr(ADDR_BAUD, {8'h00, bd});
    wr(ADDR_PWR, {8'h00, pw});
    wr(ADDR_CTRL, {8'h00, ctl});
    wr(ADDR_BUF, {8'h00, d});
    take({1'h1, ctl[7] & ctl[3], d}, ln);
    repeat (ln) @(posedge CORE_CLK);
    rd(ADDR_STAT, 32'h0000_0002, 32'h0000_0002);
    wr(ADDR_STAT, 16'h0002);
  endtask : tx_one
  initial begin
    {RST, HSEL, HADDR, HTRANS, HWRITE, HWDATA, rd_pend} = 1'h1 << 69;
    {HSIZE, T1_OVF, t1_cnt, sync_m, nine_m, cyc} = 3'h2 << 37;
    {error_cnt, check_count, seed} = 96'h0000_0039;
    repeat (6) @(posedge CORE_CLK);
    RST <= 1'h0;
    @(posedge CORE_CLK);
    rd(ADDR_STAT, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(ADDR_SADDR, 16'hA5C3);
    rd(ADDR_SADDR, 32'h0000_A5C3, 32'hFFFF_FFFF);
    for (int m = 1; m < 4; m++) begin
      tx_one({m[1:0], 6'h08}, 8'h12, 8'h80, 8'hFE, m == 2 ? 16 : 32);
    end
    rd(ADDR_RELOAD, 32'h0000_00FE, 32'hFFFF_FFFF);
    tx_one(8'h40, 8'h12, 8'h00, 8'hFD, 96);
    tx_one(8'h40, 8'h10, 8'h80, 8'hFF, 96);
    tx_one(8'h40, 8'h14, 8'h80, 8'hFE, 48);
    tx_one(8'hC0, 8'h14, 8'h00, 8'hFE, 96);
    wr(ADDR_BAUD, 16'h0002);
    wr(ADDR_BUF, 16'h0033);
    repeat (1000) @(posedge CORE_CLK);
    rd(ADDR_STAT, 32'h0000_0000, 32'h0000_0002);
    wr(ADDR_BAUD, 16'h0012);
    take(10'h233, 0);
    d = 8'(rnd());
    wr(ADDR_CTRL, 16'h00D8);
    wr(ADDR_STAT, 16'h0007);
    fork
      i_serial_peer.send({2'h2, d}, 9, 64);
      begin
        wr(ADDR_BUF, {8'h00, d | 8'h01});
        take({2'h3, d | 8'h01}, 64);
      end
    join
    rd(ADDR_BUF, {24'h00_0000, d}, 32'h0000_00FF);
    rd(ADDR_CTRL, 32'h0000_0000, 32'h0000_0004);
    wr(ADDR_CTRL, 16'h0050);
    wr(ADDR_STAT, 16'h0007);
    i_serial_peer.send({2'h2, ~d}, 8, 64);
    rd(ADDR_BUF, {24'h00_0000, ~d}, 32'h0000_00FF);
    rd(ADDR_CTRL, 32'h0000_0004, 32'h0000_0004);
    wr(ADDR_STAT, 16'h0007);
    i_serial_peer.send({2'h0, d}, 8, 64);
    rd(ADDR_STAT, 32'h0000_0004, 32'h0000_0005);
    check({31'h0000_0000, IRQ}, 32'h0000_0000);
    wr(ADDR_MASK, 16'h0004);
    @(negedge CORE_CLK);
    check({31'h0000_0000, IRQ}, 32'h0000_0001);
    @(posedge CORE_CLK);
    wr(ADDR_STAT, 16'h0004);
    @(negedge CORE_CLK);
    check({31'h0000_0000, IRQ}, 32'h0000_0000);
    @(posedge CORE_CLK);
    wr(ADDR_CTRL, 16'h00F0);
    i_serial_peer.send({2'h3, 8'hC2}, 9, 64);
    rd(ADDR_STAT, 32'h0000_0000, 32'h0000_0001);
    i_serial_peer.send({2'h3, 8'hC1}, 9, 64);
    rd(ADDR_BUF, 32'h0000_00C1, 32'h0000_00FF);
    sync_m <= 1'h1;
    wr(ADDR_BAUD, 16'h0000);
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_STAT, 16'h0007);
    d = 8'(rnd()) | 8'h01;
    wr(ADDR_BUF, {8'h00, d});
    take({2'h0, d}, 0);
    repeat (100) @(posedge CORE_CLK);
    check({31'h0000_0000, RXD_O}, 32'h0000_0001);
    rd(ADDR_STAT, 32'h0000_0002, 32'h0000_0002);
    d = 8'(rnd());
    fork
      i_serial_peer.feed(d);
      wr(ADDR_CTRL, 16'h0010);
    join
    repeat (100) @(posedge CORE_CLK);
    rd(ADDR_BUF, {24'h00_0000, d}, 32'h0000_00FF);
    rd(ADDR_STAT, 32'h0000_0001, 32'h0000_0001);
    results();
  end
endmodule : tb
bind serial_port serial_port_properties i_serial_port_properties (
  .CORE_CLK(CORE_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
  .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .T1_OVF(T1_OVF), .TXD(TXD), .RXD_I(RXD_I), .RXD_O(RXD_O),
  .RXD_OE(RXD_OE), .IRQ(IRQ));
`default_nettype wire
